/* verilog/gshi_pkg.sv */
/*
  Constants and types for the host-side serial front end of a gas sensor:
  bus address, strap timing, warm-up times, state and carrier types.
  Assumes a single 10 MHz system clock and a power-on style reset.
*/
// Operation
// RULE_01: Chip-select held high makes the serial port behave as an I2C slave.
// RULE_02: Address pin sampled at power-up is the address LSB: 0x52 or 0x53.
// RULE_03: Chip-select low once selects SPI; I2C is refused until power-on reset.
// RULE_04: Both personalities reach one shared register map.
// RULE_05: I2C works at standard, fast and fast-plus rates up to 1 Mbit/s.
// RULE_06: START, STOP, acknowledge and 7-bit address matching are provided.
// RULE_07: No 10-bit address, general call, software reset or device ID.
// RULE_08: Never a master: no clock sync, arbitration or START byte.
// RULE_09: Master sends one register-address byte before data.
// RULE_10: Register pointer increments after every data byte.
// RULE_11: Validity: 0 ok, 1 warm-up, 2 never reported, 3 out of range.
// RULE_12: Warm-up code held 2, 4 or 40 minutes by power mode.
// RULE_13: Warm-up times come from an oscillator and may vary ten percent.
// RULE_14: Read: address+W, register, re-address+R, sequential bytes to STOP.
// RULE_15: Write: address+W, register, data bytes into sequential registers.
// RULE_16: Latched address bit and interface choice stay until power-on.

package gshi_pkg;

  localparam longint CLK_PERIOD_NS = 100;
  localparam longint CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam longint MAX_BIT_HZ    = 1_000_000;

  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h52;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [1:0] STRAP_DELAY     = 2'h3;
  localparam logic [7:0] PTR_RESET       = 8'h00;

  localparam longint WARM_STD_MIN = 2;
  localparam longint WARM_LP_MIN  = 4;
  localparam longint WARM_ULP_MIN = 40;
  localparam int     WARM_CNT_W   = 36;
  localparam logic [35:0] WARM_STD_CYC = 36'(WARM_STD_MIN * 60 * CLK_HZ);
  localparam logic [35:0] WARM_LP_CYC  = 36'(WARM_LP_MIN * 60 * CLK_HZ);
  localparam logic [35:0] WARM_ULP_CYC = 36'(WARM_ULP_MIN * 60 * CLK_HZ);

  localparam logic [1:0] MODE_STD = 2'h0;
  localparam logic [1:0] MODE_LP  = 2'h1;
  localparam logic [1:0] MODE_ULP = 2'h2;

  typedef enum logic [1:0] {
    VAL_OK   = 2'h0,
    VAL_WARM = 2'h1,
    VAL_RSVD = 2'h2,
    VAL_BAD  = 2'h3
  } gshi_valid_type;

  typedef enum logic [1:0] {
    KIND_ADDR = 2'h0,
    KIND_REG  = 2'h1,
    KIND_DATA = 2'h2
  } gshi_kind_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } gshi_state_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gshi_reg_req_type;

  localparam gshi_reg_req_type REQ_RESET = '{1'b0, 1'b0, 8'h00, 8'h00};

endpackage : gshi_pkg

/* verilog/gshi_warmup.sv */
/*
  Warm-up timer and validity flag.
  Assumes power mode and the out-of-range flag come from same-clock logic.
*/
`timescale 1ns/1ps
`default_nettype none

module gshi_warmup #(
  parameter logic [35:0] STD_CYC = gshi_pkg::WARM_STD_CYC,
  parameter logic [35:0] LP_CYC  = gshi_pkg::WARM_LP_CYC,
  parameter logic [35:0] ULP_CYC = gshi_pkg::WARM_ULP_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Sensor status
  input  wire logic [1:0] power_mode,
  input  wire logic       out_of_range,
  // Flag
  output logic      [1:0] validity_r
);

  logic [35:0] cnt_r;
  logic        warm_r;

  // Nominal oscillator counts; real silicon may drift ten percent [RULE_13]
  function automatic logic [35:0] warm_limit(input logic [1:0] mode);
    case (mode)
      gshi_pkg::MODE_LP:  warm_limit = LP_CYC;
      gshi_pkg::MODE_ULP: warm_limit = ULP_CYC;
      default:            warm_limit = STD_CYC;
    endcase
  endfunction : warm_limit

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r  <= 36'h0;
      warm_r <= 1'b1;
    end else if (warm_r) begin
      if (cnt_r >= warm_limit(power_mode) - 36'h1) begin // [RULE_12]
        warm_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 36'h1;
      end
    end
  end

  // Reserved code is never produced [RULE_11]
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      validity_r <= gshi_pkg::VAL_WARM;
    end else if (warm_r) begin
      validity_r <= gshi_pkg::VAL_WARM; // [RULE_12]
    end else if (out_of_range) begin
      validity_r <= gshi_pkg::VAL_BAD; // [RULE_11]
    end else begin
      validity_r <= gshi_pkg::VAL_OK;
    end
  end

  no_reserved_a: assert property ( // [RULE_11]
    @(posedge clock) disable iff (sys_rst)
    validity_r != gshi_pkg::VAL_RSVD)
    else $error("reserved validity code reported");

  warm_hold_a: assert property ( // [RULE_12]
    @(posedge clock) disable iff (sys_rst)
    warm_r |=> validity_r == gshi_pkg::VAL_WARM)
    else $error("warm-up code not held");

  bad_flag_a: assert property ( // [RULE_11]
    @(posedge clock) disable iff (sys_rst)
    !warm_r && out_of_range |=> validity_r == gshi_pkg::VAL_BAD)
    else $error("out of range not flagged");

endmodule : gshi_warmup

`default_nettype wire

/* verilog/gshi_i2c_slave.sv */
/*
  I2C slave front end: personality select, address strap, register
  pointer with auto-increment, and the validity flag.
  Assumes the register map answers a read one clock after the rd strobe,
  and that pins are open-drain with pull-ups outside.
*/
`timescale 1ns/1ps
`default_nettype none

module gshi_i2c_slave #(
  parameter logic [35:0] WARM_STD_CYC = gshi_pkg::WARM_STD_CYC,
  parameter logic [35:0] WARM_LP_CYC  = gshi_pkg::WARM_LP_CYC,
  parameter logic [35:0] WARM_ULP_CYC = gshi_pkg::WARM_ULP_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Serial pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out_r,
  output logic            sda_oe_r,
  input  wire logic       csn_in,
  input  wire logic       addr_in,
  // Shared register map
  output var gshi_pkg::gshi_reg_req_type reg_req_r,
  input  wire logic [7:0] reg_rdata,
  // Status
  output logic            spi_sel_r,
  output logic            addr_lsb_r,
  input  wire logic [1:0] power_mode,
  input  wire logic       out_of_range,
  output logic      [1:0] validity_r
);

  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [1:0] csn_sync_r;
  logic [1:0] adr_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [1:0] strap_cnt_r;
  logic       addr_taken_r;

  gshi_pkg::gshi_state_type state_r;
  gshi_pkg::gshi_kind_type  kind_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic       rw_r;
  logic       ack_ok_r;
  logic       rd_pend_r;

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_full;
  logic addr_hit;

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s; // [RULE_06]
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s; // [RULE_06]
  assign byte_full = (bitcnt_r == gshi_pkg::BITS_PER_BYTE);
  // Only the one 7-bit address matches; general call and 10-bit prefixes
  // fall through as a miss [RULE_07]
  assign addr_hit  = addr_taken_r && // [RULE_02]
    (shift_r[7:1] == {gshi_pkg::SLAVE_ADDR_BASE[6:1], addr_lsb_r});

  // Two-stage synchronisers; at 1 Mbit/s a high phase spans five samples
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      csn_sync_r <= 2'h3;
      adr_sync_r <= 2'h0;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in}; // [RULE_05]
      sda_sync_r <= {sda_sync_r[0], sda_in};
      csn_sync_r <= {csn_sync_r[0], csn_in};
      adr_sync_r <= {adr_sync_r[0], addr_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  // Strap is caught once after release, then frozen
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_cnt_r  <= 2'h0;
      addr_taken_r <= 1'b0;
      addr_lsb_r   <= 1'b0;
    end else if (!addr_taken_r) begin
      if (strap_cnt_r == gshi_pkg::STRAP_DELAY) begin
        addr_lsb_r   <= adr_sync_r[1]; // [RULE_02] [RULE_16]
        addr_taken_r <= 1'b1;
      end else begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  // Sticky personality choice; only reset clears it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      spi_sel_r <= 1'b0;
    end else if (!csn_sync_r[1]) begin
      spi_sel_r <= 1'b1; // [RULE_03] [RULE_16]
    end
  end

  // Never drives a high level and has no clock output at all [RULE_08]
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  // Protocol engine; SDA changes only after a falling SCL edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r   <= gshi_pkg::ST_IDLE;
      kind_r    <= gshi_pkg::KIND_ADDR;
      bitcnt_r  <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= gshi_pkg::PTR_RESET;
      rw_r      <= 1'b0;
      ack_ok_r  <= 1'b0;
      rd_pend_r <= 1'b0;
      sda_oe_r  <= 1'b0;
      reg_req_r <= gshi_pkg::REQ_RESET;
    end else begin
      reg_req_r.wr <= 1'b0;
      reg_req_r.rd <= 1'b0;
      rd_pend_r    <= reg_req_r.rd;
      if (rd_pend_r) begin
        tx_r  <= reg_rdata; // [RULE_04]
        ptr_r <= ptr_r + 8'h01; // [RULE_10]
      end
      if (spi_sel_r) begin
        state_r  <= gshi_pkg::ST_IDLE; // [RULE_03]
        sda_oe_r <= 1'b0;
      end else if (start_det) begin
        state_r  <= gshi_pkg::ST_RX; // [RULE_01] [RULE_06]
        kind_r   <= gshi_pkg::KIND_ADDR;
        bitcnt_r <= 4'h0;
        rw_r     <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (stop_det) begin
        state_r  <= gshi_pkg::ST_IDLE; // [RULE_06]
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          gshi_pkg::ST_RX: begin
            if (scl_rise && !byte_full) begin
              shift_r  <= {shift_r[6:0], sda_s};
              bitcnt_r <= bitcnt_r + 4'h1;
            end else if (scl_fall && byte_full) begin
              bitcnt_r <= 4'h0;
              case (kind_r)
                gshi_pkg::KIND_ADDR: begin
                  if (addr_hit) begin
                    state_r  <= gshi_pkg::ST_ACK; // [RULE_06]
                    sda_oe_r <= 1'b1;
                    rw_r     <= shift_r[0];
                    if (shift_r[0]) begin
                      reg_req_r.rd   <= 1'b1; // [RULE_14]
                      reg_req_r.addr <= ptr_r;
                    end
                  end else begin
                    state_r <= gshi_pkg::ST_IDLE; // [RULE_07]
                  end
                end
                gshi_pkg::KIND_REG: begin
                  ptr_r    <= shift_r; // [RULE_09]
                  state_r  <= gshi_pkg::ST_ACK;
                  sda_oe_r <= 1'b1;
                end
                default: begin
                  reg_req_r.wr    <= 1'b1; // [RULE_15]
                  reg_req_r.addr  <= ptr_r;
                  reg_req_r.wdata <= shift_r;
                  ptr_r           <= ptr_r + 8'h01; // [RULE_10]
                  state_r         <= gshi_pkg::ST_ACK;
                  sda_oe_r        <= 1'b1;
                end
              endcase
            end
          end
          gshi_pkg::ST_ACK: begin
            if (scl_fall) begin
              bitcnt_r <= 4'h0;
              if (rw_r) begin
                state_r  <= gshi_pkg::ST_TX;
                sda_oe_r <= ~tx_r[7];
              end else begin
                state_r  <= gshi_pkg::ST_RX;
                sda_oe_r <= 1'b0;
                kind_r   <= (kind_r == gshi_pkg::KIND_ADDR) ?
                            gshi_pkg::KIND_REG : gshi_pkg::KIND_DATA;
              end
            end
          end
          gshi_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bitcnt_r == gshi_pkg::BITS_PER_BYTE - 4'h1) begin
                state_r  <= gshi_pkg::ST_MACK;
                sda_oe_r <= 1'b0;
                ack_ok_r <= 1'b0;
              end else begin
                tx_r     <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
                bitcnt_r <= bitcnt_r + 4'h1;
              end
            end
          end
          gshi_pkg::ST_MACK: begin
            if (scl_rise) begin
              ack_ok_r <= ~sda_s;
              if (!sda_s) begin
                reg_req_r.rd   <= 1'b1; // [RULE_10] [RULE_14]
                reg_req_r.addr <= ptr_r;
              end
            end else if (scl_fall) begin
              bitcnt_r <= 4'h0;
              if (ack_ok_r) begin
                state_r  <= gshi_pkg::ST_TX;
                sda_oe_r <= ~tx_r[7];
              end else begin
                state_r <= gshi_pkg::ST_IDLE;
              end
            end
          end
          gshi_pkg::ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            state_r  <= gshi_pkg::ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  gshi_warmup #(
    .STD_CYC (WARM_STD_CYC),
    .LP_CYC  (WARM_LP_CYC),
    .ULP_CYC (WARM_ULP_CYC)
  ) u_warmup (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .power_mode   (power_mode),
    .out_of_range (out_of_range),
    .validity_r   (validity_r)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence addr_byte_done;
    state_r == gshi_pkg::ST_RX && kind_r == gshi_pkg::KIND_ADDR &&
    scl_fall && byte_full && !start_det && !stop_det && !spi_sel_r;
  endsequence

  sequence read_fetch;
    reg_req_r.rd ##1 1'b1;
  endsequence

  spi_sticky_a: assert property (spi_sel_r |=> spi_sel_r) // [RULE_03]
    else $error("interface selection lost");

  spi_quiet_a: assert property (spi_sel_r |=> !sda_oe_r && // [RULE_03]
    state_r == gshi_pkg::ST_IDLE)
    else $error("I2C active after SPI selection");

  strap_stable_a: assert property (addr_taken_r |=> // [RULE_16]
    $stable(addr_lsb_r) && addr_taken_r)
    else $error("address strap changed");

  addr_ack_a: assert property (addr_byte_done and addr_hit |=> // [RULE_02]
    state_r == gshi_pkg::ST_ACK && sda_oe_r)
    else $error("own address not acknowledged");

  addr_miss_a: assert property (addr_byte_done and !addr_hit |=> // [RULE_07]
    state_r == gshi_pkg::ST_IDLE && !sda_oe_r)
    else $error("foreign address acknowledged");

  start_seen_a: assert property (start_det && !spi_sel_r |=> // [RULE_01]
    state_r == gshi_pkg::ST_RX && bitcnt_r == 4'h0)
    else $error("START not taken");

  stop_seen_a: assert property (stop_det && !start_det |=> // [RULE_06]
    state_r == gshi_pkg::ST_IDLE && !sda_oe_r)
    else $error("STOP not taken");

  write_inc_a: assert property (reg_req_r.wr |-> // [RULE_10]
    ptr_r == reg_req_r.addr + 8'h01)
    else $error("pointer not advanced after write");

  read_load_a: assert property (read_fetch |=> // [RULE_14]
    tx_r == $past(reg_rdata) && ptr_r == $past(reg_req_r.addr, 2) + 8'h01)
    else $error("read data or pointer wrong");

endmodule : gshi_i2c_slave

`default_nettype wire

/* test/gshi_host_model.sv */
/*
  Behavioural I2C bus master standing in for the host processor.
  Assumes the bench resolves the open-drain SDA wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module gshi_host_model (
  // Clock
  input  wire logic clock,
  // Bus pins
  output logic      scl_o,
  output logic      sda_low,
  input  wire logic sda_bus
);
  int         half;
  logic [7:0] rx_byte;
  event       rx_ev;

  initial begin
    half    = 5;
    scl_o   = 1'b1;
    sda_low = 1'b0;
    rx_byte = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  // SDA moves only one clock after SCL falls, so no false START or STOP
  task automatic pulse(output logic seen);
    tick(half);
    scl_o = 1'b1;
    seen  = sda_bus;
    tick(half);
    scl_o = 1'b0;
    tick(1);
  endtask : pulse

  // Also serves as repeated START when SCL is low
  task automatic start_cond;
    sda_low = 1'b0;
    tick(half);
    scl_o   = 1'b1;
    tick(half);
    sda_low = 1'b1;
    tick(half);
    scl_o   = 1'b0;
    tick(1);
  endtask : start_cond

  task automatic stop_cond;
    sda_low = 1'b1;
    tick(half);
    scl_o   = 1'b1;
    tick(half);
    sda_low = 1'b0;
    tick(half);
  endtask : stop_cond

  task automatic send(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      pulse(seen);
    end
    sda_low = 1'b0;
    pulse(seen);
    ack = ~seen;
  endtask : send

  // A low more means NACK, which ends the read
  task automatic get(input logic more);
    logic seen;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(seen);
      rx_byte[i] = seen;
    end
    // Acknowledge level stays until the next task sets SDA
    sda_low = more;
    pulse(seen);
    -> rx_ev;
  endtask : get
endmodule : gshi_host_model

`default_nettype wire

/* test/tb_gshi_i2c_slave.sv */
/*
  Self-checking bench for the I2C slave front end.
  Assumes short warm-up parameters and the behavioural host model.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_gshi_i2c_slave;
  localparam logic [35:0] STD_C = 36'h32;
  logic                       clock;
  logic                       sys_rst;
  logic                       csn_in;
  logic                       addr_in;
  logic [1:0]                 power_mode;
  logic                       out_of_range;
  logic                       scl;
  logic                       host_low;
  logic                       sda_out_r;
  logic                       sda_oe_r;
  logic                       spi_sel_r;
  logic                       addr_lsb_r;
  logic [1:0]                 validity_r;
  logic [7:0]                 reg_rdata;
  gshi_pkg::gshi_reg_req_type reg_req_r;
  logic [15:0]                rnd;
  logic [7:0]                 key;
  logic                       strap;
  logic [6:0]                 slv;
  logic [7:0]                 bad [4];
  int                         halves [2] = '{5, 50};
  int                         lim;
  int                         errors;
  int                         checks;
  logic [15:0]                wq [$];
  logic [7:0]                 rq [$];
  wire                        sda = ~(host_low | sda_oe_r);

  // Stand-in register map: data is a keyed copy of the address
  assign reg_rdata = reg_req_r.addr ^ key;

  gshi_i2c_slave #(
    .WARM_STD_CYC(STD_C),
    .WARM_LP_CYC (36'h64),
    .WARM_ULP_CYC(36'hc8)
  ) gshi_i2c_slave_inst (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r), .csn_in(csn_in),
    .addr_in(addr_in), .reg_req_r(reg_req_r), .reg_rdata(reg_rdata),
    .spi_sel_r(spi_sel_r), .addr_lsb_r(addr_lsb_r),
    .power_mode(power_mode), .out_of_range(out_of_range),
    .validity_r(validity_r)
  );

  gshi_host_model gshi_host_model_inst (
    .clock(clock), .scl_o(scl), .sda_low(host_low), .sda_bus(sda)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction : lfsr

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
  endtask : do_reset

  task automatic put(input logic [7:0] b, input logic exp);
    logic ack;
    gshi_host_model_inst.send(b, ack);
    check(16'(ack), 16'(exp));
  endtask : put

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    repeat (60000) @(negedge clock);
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize();
  end

  // Each register write pulse takes the oldest expected write
  always @(negedge clock) begin
    if (reg_req_r.wr === 1'b1) begin
      if (wq.size() == 0) check(16'(reg_req_r.wr), 16'h0);
      else check({reg_req_r.addr, reg_req_r.wdata},
                 wq.pop_front());
    end
  end

  initial forever begin
    @(gshi_host_model_inst.rx_ev);
    if (rq.size() == 0) check(16'h1, 16'h0);
    else check(16'(gshi_host_model_inst.rx_byte),
               16'(rq.pop_front()));
  end

  initial begin
    errors = 0;
    checks = 0;
    rnd = 16'd61159;
    key = 8'h00;
    sys_rst = 1'b1;
    csn_in = 1'b1;
    power_mode = 2'h0;
    out_of_range = 1'b0;
    strap = rnd[0];
    addr_in = strap;
    do_reset();
    // Ten percent margins either side allow for oscillator drift
    for (int m = 0; m < 3; m++) begin
      power_mode = m[1:0];
      lim = int'(STD_C) << m;
      repeat (lim * 9 / 10) @(negedge clock);
      check(16'(validity_r), 16'h1);
      repeat (lim / 5) @(negedge clock);
      check(16'(validity_r), 16'h0);
      check(16'(addr_lsb_r), 16'(strap));
      // Flip the strap once so both address values see a power-up
      if (m == 0) strap = ~strap;
      addr_in = strap;
      if (m < 2) do_reset();
    end
    out_of_range = 1'b1;
    repeat (3) @(negedge clock);
    check(16'(validity_r), 16'h3);
    out_of_range = 1'b0;
    repeat (3) @(negedge clock);
    check(16'(validity_r), 16'h0);
    check(16'(addr_lsb_r), 16'(strap));
    addr_in = ~strap;
    slv = gshi_pkg::SLAVE_ADDR_BASE | 7'(strap);
    bad = '{{slv ^ 7'h01, 1'b0}, 8'h00, 8'hf0, 8'hf8};
    foreach (halves[k]) begin
      gshi_host_model_inst.half = halves[k];
      gshi_host_model_inst.start_cond();
      put({slv, 1'b0}, 1'b1);
      put(8'h10, 1'b1);
      for (int i = 0; i < 4; i++) begin
        rnd = lfsr(rnd);
        wq.push_back({8'h10 + 8'(i), rnd[7:0]});
        put(rnd[7:0], 1'b1);
      end
      gshi_host_model_inst.stop_cond();
      key = rnd[15:8];
      gshi_host_model_inst.start_cond();
      put({slv, 1'b0}, 1'b1);
      put(8'h20, 1'b1);
      gshi_host_model_inst.start_cond();
      put({slv, 1'b1}, 1'b1);
      for (int i = 0; i < 4; i++) begin
        rq.push_back((8'h20 + 8'(i)) ^ key);
        gshi_host_model_inst.get(i < 3);
      end
      gshi_host_model_inst.stop_cond();
    end
    foreach (bad[k]) begin
      gshi_host_model_inst.start_cond();
      put(bad[k], 1'b0);
      gshi_host_model_inst.stop_cond();
    end
    check(16'(spi_sel_r), 16'h0);
    csn_in = 1'b0;
    repeat (4) @(negedge clock);
    csn_in = 1'b1;
    check(16'(spi_sel_r), 16'h1);
    gshi_host_model_inst.start_cond();
    put({slv, 1'b0}, 1'b0);
    gshi_host_model_inst.stop_cond();
    check(16'(spi_sel_r), 16'h1);
    check(16'(addr_lsb_r), 16'(strap));
    check(16'(sda_out_r), 16'h0);
    check(16'(wq.size() + rq.size()), 16'h0);
    summarize();
  end
endmodule : tb_gshi_i2c_slave

`default_nettype wire
